/* File: design/pns_cfg.svh */
/*
 * Offsets, field positions, reset values and widths of the next-page
 * transmit and status summary register bank.
 * Assumes it is included by its bare name from design and bench files.
 */
`ifndef PNS_CFG_SVH
`define PNS_CFG_SVH

// Register indices; byte address is four times the index
`define PNS_IDX_AN_EXPANSION   6'h06
`define PNS_IDX_NEXT_PAGE_TX   6'h07
`define PNS_IDX_STATUS_SUMMARY 6'h10
`define PNS_IDX_FALSE_CARRIER  6'h14
`define PNS_IDX_RX_ERROR       6'h15
`define PNS_IDX_TENBASE_STATUS 6'h1A
`define PNS_IDX_INT_STATUS     6'h1E
`define PNS_IDX_INT_MASK       6'h1F

`define PNS_ADDR_W             8
`define PNS_DATA_W             32
`define PNS_REG_W              16

// Next-page transmit fields
`define PNS_NP_NEXT_BIT        15
`define PNS_NP_MSG_BIT         13
`define PNS_NP_WILL_COMPLY_ACK_BIT        12
`define PNS_NP_TOG_BIT         11
`define PNS_NP_CODE_W          11
`define PNS_NP_CODE_RST        11'h001
`define PNS_NP_NEXT_RST        1'h0
`define PNS_NP_MSG_RST         1'h1
`define PNS_NP_WILL_COMPLY_ACK_RST        1'h0

// Status summary fields
`define PNS_SS_RXERR_BIT       13
`define PNS_SS_POL_BIT         12
`define PNS_SS_FC_BIT          11
`define PNS_SS_SD_BIT          10
`define PNS_SS_LOCK_BIT        9
`define PNS_SS_PAGE_BIT        8

// Other registers
`define PNS_EXP_PAGE_BIT       1
`define PNS_TB_POL_BIT         4

// Latch-high sources: 0 rx error, 1 false carrier, 2 polarity, 3 page
`define PNS_LH_N               4
// Latch-low sources: 0 signal detect, 1 descrambler lock
`define PNS_LL_N               2
// Interrupt events: rx err, false carrier, page, sd drop, lock drop
`define PNS_EV_N               5
`define PNS_EV_MASK_RST        5'h00

`endif

/* File: design/pns_pkg.sv */
/*
 * Types shared by the register bank modules.
 * Assumes pns_cfg.svh is on the include path.
 */
`include "pns_cfg.svh"

package pns_pkg;
  typedef logic [`PNS_REG_W-1:0]  pns_reg_t;
  typedef logic [`PNS_EV_N-1:0]   pns_ev_t;
  typedef logic [5:0]             pns_idx_t;
endpackage

/* File: design/pns_lat_if.sv */
/*
 * Interface between the register bank and its latch unit.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pns_cfg.svh"

interface pns_lat_if;
  logic [`PNS_LH_N-1:0] lh_src;
  logic [`PNS_LH_N-1:0] lh_clr;
  logic [`PNS_LH_N-1:0] lh_q;
  logic [`PNS_LL_N-1:0] ll_src;
  logic                 ll_clr;
  logic [`PNS_LL_N-1:0] ll_q;
  logic [`PNS_LL_N-1:0] ll_drop;

  modport latch (input lh_src, lh_clr, ll_src, ll_clr, output lh_q, ll_q, ll_drop);
  modport ctrl  (output lh_src, lh_clr, ll_src, ll_clr, input lh_q, ll_q, ll_drop);
endinterface

`default_nettype wire

/* File: design/pns_latch_bank.sv */
/*
 * Latch-high and latch-low status cells.
 * Assumes sources and clears are synchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pns_cfg.svh"

module pns_latch_bank #(
  parameter int LH_N = `PNS_LH_N,
  parameter int LL_N = `PNS_LL_N
) (
  input  wire logic clk,
  input  wire logic rst,
  pns_lat_if.latch  lat
);
  logic [LL_N-1:0] held_q;

  genvar i;
  generate
    for (i = 0; i < LH_N; i++) begin : g_lh
      // Set wins over a clear in the same cycle
      always_ff @(posedge clk) begin
        if (rst) begin
          lat.lh_q[i] <= 1'h0;
        end else begin
          lat.lh_q[i] <= lat.lh_src[i] | (lat.lh_q[i] & ~lat.lh_clr[i]);
        end
      end
    end
    for (i = 0; i < LL_N; i++) begin : g_ll
      // Held low from reset until the first read
      always_ff @(posedge clk) begin
        if (rst) begin
          held_q[i] <= 1'h1;
        end else begin
          held_q[i] <= ~lat.ll_src[i] | (held_q[i] & ~lat.ll_clr);  // RQ14
        end
      end
      assign lat.ll_q[i]    = lat.ll_src[i] & ~held_q[i];
      assign lat.ll_drop[i] = ~lat.ll_src[i] & ~held_q[i];
    end
  endgenerate
endmodule

`default_nettype wire

/* File: design/pns_regs.sv */
/*
 * Next-page transmit and status summary registers behind an APB slave,
 * with a read-to-clear interrupt status and mask.
 * Assumes all event and level inputs come from logic on MCLK.
 */
// Functional notes
// [RQ1] Bit 12 of the next-page register is a read/write will-comply flag, reset 0.
// [RQ2] Bit 11 of the next-page register reads the inverse of the last exchanged toggle.
// [RQ3] Bits 10:0 of the next-page register are a read/write code, reset to the null page 1.
// [RQ4] The code goes out as a message page when bit 13 is 1, else as unformatted.
// [RQ5] Status summary bits 15:14 ignore writes and read as 0.
// [RQ6] Status summary bit 13 latches any receive error until the rx error counter is read.
// [RQ7] Status summary bit 12 mirrors the 10 Mb/s polarity bit, 1 meaning inverted.
// [RQ8] That polarity bit clears on a 10 Mb/s status read, not on a summary read.
// [RQ9] Status summary bit 11 latches false carrier until the false carrier counter is read.
// [RQ10] Status summary bit 10 is the latch-low 100 Mb/s signal detect, reset 0.
// [RQ11] Status summary bit 9 is the latch-low descrambler lock, reset 0.
// [RQ12] Status summary bit 8 mirrors page received; only an expansion read clears it.
// [RQ13] Expansion bit 1 sets when a link code word arrives and clears when read.
// [RQ14] A latch-low bit reads 0 after any drop until read, then follows its source.
`timescale 1ns/1ps
`default_nettype none
`include "pns_cfg.svh"

module pns_regs (
  input  wire logic                   MCLK,
  input  wire logic                   RST,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [`PNS_ADDR_W-1:0] PADDR,
  input  wire logic [`PNS_DATA_W-1:0] PWDATA,
  output logic      [`PNS_DATA_W-1:0] PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic                   RX_ERR_EVT,
  input  wire logic                   FALSE_CARRIER_EVT,
  input  wire logic                   POLARITY_INV,
  input  wire logic                   SIGNAL_DETECT,
  input  wire logic                   DESCRAMBLER_LOCK,
  input  wire logic                   LCW_RECEIVED,
  input  wire logic                   LCW_EXCHANGED,
  input  wire logic                   LCW_TOGGLE,
  output logic                        NP_NEXT_PAGE,
  output logic                        NP_MESSAGE_PAGE,
  output logic                        NP_WILL_COMPLY_ACK,
  output logic                        NP_TOGGLE,
  output logic [`PNS_NP_CODE_W-1:0]   NP_CODE,
  output logic                        IRQ
);
  pns_lat_if lat ();

  pns_pkg::pns_idx_t idx;
  pns_pkg::pns_reg_t rdata_d;
  pns_pkg::pns_reg_t ss_val;
  pns_pkg::pns_ev_t  ev;
  pns_pkg::pns_ev_t  int_stat_q;
  pns_pkg::pns_ev_t  int_mask_q;
  logic              acc;
  logic              rd;
  logic              wr;
  logic              hit;
  logic              rd_exp;
  logic              rd_ss;
  logic              rd_fc;
  logic              rd_rx;
  logic              rd_tb;
  logic              rd_int;
  logic              wr_np;
  logic              addr_ok;

  // Access taken one cycle before PREADY, so a read's clear and its data agree
  assign acc    = PSEL & PENABLE & ~PREADY;
  assign addr_ok = hit & (PADDR[1:0] == 2'h0);
  assign rd     = acc & ~PWRITE & addr_ok;
  assign wr     = acc & PWRITE & addr_ok;
  assign idx    = PADDR[7:2];
  assign rd_exp = rd & (idx == `PNS_IDX_AN_EXPANSION);
  assign rd_ss  = rd & (idx == `PNS_IDX_STATUS_SUMMARY);
  assign rd_fc  = rd & (idx == `PNS_IDX_FALSE_CARRIER);
  assign rd_rx  = rd & (idx == `PNS_IDX_RX_ERROR);
  assign rd_tb  = rd & (idx == `PNS_IDX_TENBASE_STATUS);
  assign rd_int = rd & (idx == `PNS_IDX_INT_STATUS);
  assign wr_np  = wr & (idx == `PNS_IDX_NEXT_PAGE_TX);

  always_comb begin
    hit = 1'h0;
    case (idx)
      `PNS_IDX_AN_EXPANSION,
      `PNS_IDX_NEXT_PAGE_TX,
      `PNS_IDX_STATUS_SUMMARY,
      `PNS_IDX_FALSE_CARRIER,
      `PNS_IDX_RX_ERROR,
      `PNS_IDX_TENBASE_STATUS,
      `PNS_IDX_INT_STATUS,
      `PNS_IDX_INT_MASK: hit = 1'h1;
      default: hit = 1'h0;
    endcase
  end

  // Latch sources and their clearing reads
  assign lat.lh_src = {LCW_RECEIVED, POLARITY_INV, FALSE_CARRIER_EVT, RX_ERR_EVT};
  assign lat.lh_clr = {rd_exp, rd_tb, rd_fc, rd_rx};  // RQ6 RQ8 RQ9 RQ13
  assign lat.ll_src = {DESCRAMBLER_LOCK, SIGNAL_DETECT};
  assign lat.ll_clr = rd_ss;  // RQ14

  pns_latch_bank #(
    .LH_N (`PNS_LH_N),
    .LL_N (`PNS_LL_N)
  ) u_latch (
    .clk (MCLK),
    .rst (RST),
    .lat (lat)
  );

  always_comb begin
    ss_val = 16'h0000;  // RQ5
    ss_val[`PNS_SS_RXERR_BIT] = lat.lh_q[0];  // RQ6
    ss_val[`PNS_SS_POL_BIT]   = lat.lh_q[2];  // RQ7
    ss_val[`PNS_SS_FC_BIT]    = lat.lh_q[1];  // RQ9
    ss_val[`PNS_SS_SD_BIT]    = lat.ll_q[0];  // RQ10
    ss_val[`PNS_SS_LOCK_BIT]  = lat.ll_q[1];  // RQ11
    ss_val[`PNS_SS_PAGE_BIT]  = lat.lh_q[3];  // RQ12
  end

  // Next-page transmit register
  always_ff @(posedge MCLK) begin
    if (RST) begin
      NP_NEXT_PAGE    <= `PNS_NP_NEXT_RST;
      NP_MESSAGE_PAGE <= `PNS_NP_MSG_RST;
      NP_WILL_COMPLY_ACK         <= `PNS_NP_WILL_COMPLY_ACK_RST;
      NP_CODE         <= `PNS_NP_CODE_RST;  // RQ3
    end else if (wr_np) begin
      NP_NEXT_PAGE    <= PWDATA[`PNS_NP_NEXT_BIT];
      NP_MESSAGE_PAGE <= PWDATA[`PNS_NP_MSG_BIT];  // RQ4
      NP_WILL_COMPLY_ACK         <= PWDATA[`PNS_NP_WILL_COMPLY_ACK_BIT];  // RQ1
      NP_CODE         <= PWDATA[`PNS_NP_CODE_W-1:0];  // RQ3
    end
  end

  // Software cannot write the toggle; it follows each exchanged word
  always_ff @(posedge MCLK) begin
    if (RST) begin
      NP_TOGGLE <= 1'h0;
    end else if (LCW_EXCHANGED) begin
      NP_TOGGLE <= ~LCW_TOGGLE;  // RQ2
    end
  end

  // Interrupt status and mask
  assign ev = {lat.ll_drop[1], lat.ll_drop[0], LCW_RECEIVED, FALSE_CARRIER_EVT, RX_ERR_EVT};

  always_ff @(posedge MCLK) begin
    if (RST) begin
      int_stat_q <= 5'h00;
    end else begin
      int_stat_q <= ev | (int_stat_q & {`PNS_EV_N{~rd_int}});
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      int_mask_q <= `PNS_EV_MASK_RST;
    end else if (wr & (idx == `PNS_IDX_INT_MASK)) begin
      int_mask_q <= PWDATA[`PNS_EV_N-1:0];
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      IRQ <= 1'h0;
    end else begin
      IRQ <= |(int_stat_q & int_mask_q);
    end
  end

  // Read data mux
  always_comb begin
    rdata_d = 16'h0000;
    case (idx)
      `PNS_IDX_AN_EXPANSION:   rdata_d[`PNS_EXP_PAGE_BIT] = lat.lh_q[3];  // RQ13
      `PNS_IDX_NEXT_PAGE_TX:   rdata_d = {NP_NEXT_PAGE, 1'h0, NP_MESSAGE_PAGE, NP_WILL_COMPLY_ACK,
                                          NP_TOGGLE, NP_CODE};
      `PNS_IDX_STATUS_SUMMARY: rdata_d = ss_val;
      `PNS_IDX_TENBASE_STATUS: rdata_d[`PNS_TB_POL_BIT] = lat.lh_q[2];
      `PNS_IDX_INT_STATUS:     rdata_d[`PNS_EV_N-1:0] = int_stat_q;
      `PNS_IDX_INT_MASK:       rdata_d[`PNS_EV_N-1:0] = int_mask_q;
      default:                 rdata_d = 16'h0000;
    endcase
  end

  // One wait state: PREADY rises the cycle after the access phase opens
  always_ff @(posedge MCLK) begin
    if (RST) begin
      PREADY  <= 1'h0;
      PSLVERR <= 1'h0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= acc;
      PSLVERR <= acc & ~addr_ok;
      if (acc & ~PWRITE) begin
        PRDATA <= {16'h0000, (addr_ok ? rdata_d : 16'h0000)};
      end
    end
  end

  sequence np_write_s;
    wr_np;
  endsequence

  sequence ss_read_s;
    rd_ss ##1 PREADY;
  endsequence

  will_comply_ack_write_a: assert property (@(posedge MCLK) disable iff (RST) // RQ1
    np_write_s |=> (NP_WILL_COMPLY_ACK == $past(PWDATA[`PNS_NP_WILL_COMPLY_ACK_BIT])) && PREADY)
    else $error("will-comply flag not taken from write");

  toggle_inv_a: assert property (@(posedge MCLK) disable iff (RST) // RQ2
    LCW_EXCHANGED ##1 (!LCW_EXCHANGED && !wr_np) [*2] |-> NP_TOGGLE == !$past(LCW_TOGGLE, 2))
    else $error("toggle not inverse of exchanged word");

  code_reset_a: assert property (@(posedge MCLK) disable iff (RST) // RQ3
    $past(RST) |-> NP_CODE == `PNS_NP_CODE_RST && !NP_WILL_COMPLY_ACK && NP_MESSAGE_PAGE)
    else $error("next-page reset value wrong");

  msg_page_a: assert property (@(posedge MCLK) disable iff (RST) // RQ4
    np_write_s |=> NP_MESSAGE_PAGE == $past(PWDATA[`PNS_NP_MSG_BIT]))
    else $error("message page flag not written");

  ss_reserved_a: assert property (@(posedge MCLK) disable iff (RST) // RQ5
    ss_read_s |-> PRDATA[15:14] == 2'h0)
    else $error("reserved status bits not zero");

  rxerr_latch_a: assert property (@(posedge MCLK) disable iff (RST) // RQ6
    RX_ERR_EVT ##1 !rd_rx [*3] |-> ss_val[`PNS_SS_RXERR_BIT])
    else $error("receive error latch lost");

  pol_keep_a: assert property (@(posedge MCLK) disable iff (RST) // RQ8
    lat.lh_q[2] && rd_ss && !rd_tb |=> ss_val[`PNS_SS_POL_BIT])
    else $error("polarity cleared by summary read");

  pol_mirror_a: assert property (@(posedge MCLK) disable iff (RST) // RQ7
    POLARITY_INV |=> ss_val[`PNS_SS_POL_BIT] && (PRDATA[`PNS_TB_POL_BIT] || !$past(rd_tb)))
    else $error("polarity mirror not set");

  fc_clear_a: assert property (@(posedge MCLK) disable iff (RST) // RQ9
    rd_fc && !FALSE_CARRIER_EVT |=> !ss_val[`PNS_SS_FC_BIT] && PREADY)
    else $error("false carrier latch not cleared by counter read");

  sd_low_a: assert property (@(posedge MCLK) disable iff (RST) // RQ10
    !SIGNAL_DETECT ##1 (!rd_ss) [*2] |-> !ss_val[`PNS_SS_SD_BIT])
    else $error("signal detect drop not held");

  lock_low_a: assert property (@(posedge MCLK) disable iff (RST) // RQ11
    !DESCRAMBLER_LOCK ##1 (!rd_ss) [*2] |-> !ss_val[`PNS_SS_LOCK_BIT])
    else $error("descrambler lock drop not held");

  page_keep_a: assert property (@(posedge MCLK) disable iff (RST) // RQ12
    lat.lh_q[3] && rd_ss |=> ss_val[`PNS_SS_PAGE_BIT])
    else $error("page received cleared by summary read");

  page_clear_a: assert property (@(posedge MCLK) disable iff (RST) // RQ13
    rd_exp && !LCW_RECEIVED |=> !ss_val[`PNS_SS_PAGE_BIT])
    else $error("page received not cleared by expansion read");

  ll_follow_a: assert property (@(posedge MCLK) disable iff (RST) // RQ14
    rd_ss && SIGNAL_DETECT ##1 SIGNAL_DETECT |-> ss_val[`PNS_SS_SD_BIT])
    else $error("latch-low bit does not follow source after read");

  toggle_ro_a: assert property (@(posedge MCLK) disable iff (RST) // RQ2
    wr_np && !LCW_EXCHANGED |=> $stable(NP_TOGGLE))
    else $error("toggle changed by a register write");

  code_write_a: assert property (@(posedge MCLK) disable iff (RST) // RQ3
    np_write_s |=> NP_CODE == $past(PWDATA[`PNS_NP_CODE_W-1:0]))
    else $error("code field not taken from write");

  bad_write_a: assert property (@(posedge MCLK) disable iff (RST) // RQ1 RQ3
    acc && PWRITE && (PADDR[1:0] != 2'h0) |=> $stable(NP_CODE) && $stable(NP_WILL_COMPLY_ACK))
    else $error("misaligned write changed next-page register");

  err_resp_a: assert property (@(posedge MCLK) disable iff (RST)
    acc && (PADDR[1:0] != 2'h0) |=> PREADY && PSLVERR)
    else $error("misaligned access not flagged");

  rx_clear_a: assert property (@(posedge MCLK) disable iff (RST) // RQ6
    rd_rx && !RX_ERR_EVT |=> !ss_val[`PNS_SS_RXERR_BIT])
    else $error("receive error latch not cleared by counter read");

  pol_clear_a: assert property (@(posedge MCLK) disable iff (RST) // RQ8
    rd_tb && !POLARITY_INV |=> !ss_val[`PNS_SS_POL_BIT])
    else $error("polarity not cleared by 10 Mb/s status read");

  fc_latch_a: assert property (@(posedge MCLK) disable iff (RST) // RQ9
    FALSE_CARRIER_EVT ##1 !rd_fc [*3] |-> ss_val[`PNS_SS_FC_BIT])
    else $error("false carrier latch lost");

  page_latch_a: assert property (@(posedge MCLK) disable iff (RST) // RQ12
    LCW_RECEIVED ##1 !rd_exp [*2] |-> ss_val[`PNS_SS_PAGE_BIT])
    else $error("page received mirror lost");
endmodule

`default_nettype wire

/* File: sim/test_phy_next_page_and_status_regs.sv */
/*
 * Self-checking bench for the next-page transmit and status summary bank.
 * Assumes pns_cfg.svh on the include path and a one-wait-state APB slave.
 */
`timescale 1ns/1ps
`default_nettype none
`include "pns_cfg.svh"

module test_phy_next_page_and_status_regs;
  localparam logic [7:0]  A_EXP  = {`PNS_IDX_AN_EXPANSION, 2'h0};
  localparam logic [7:0]  A_NP   = {`PNS_IDX_NEXT_PAGE_TX, 2'h0};
  localparam logic [7:0]  A_SS   = {`PNS_IDX_STATUS_SUMMARY, 2'h0};
  localparam logic [7:0]  A_FC   = {`PNS_IDX_FALSE_CARRIER, 2'h0};
  localparam logic [7:0]  A_RX   = {`PNS_IDX_RX_ERROR, 2'h0};
  localparam logic [7:0]  A_TB   = {`PNS_IDX_TENBASE_STATUS, 2'h0};
  localparam logic [7:0]  A_IS   = {`PNS_IDX_INT_STATUS, 2'h0};
  localparam logic [7:0]  A_IM   = {`PNS_IDX_INT_MASK, 2'h0};
  localparam logic [31:0] BASE   = 32'h0000_0600;

  logic                      mclk;
  logic                      rst;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [`PNS_ADDR_W-1:0]    paddr;
  logic [`PNS_DATA_W-1:0]    pwdata;
  logic [`PNS_DATA_W-1:0]    prdata;
  logic                      pready;
  logic                      pslverr;
  logic                      rx_err;
  logic                      fc;
  logic                      pol;
  logic                      sd;
  logic                      lock;
  logic                      lcw_rx;
  logic                      lcw_ex;
  logic                      lcw_tog;
  logic                      np_next;
  logic                      np_msg;
  logic                      np_will_comply_ack;
  logic                      np_tog;
  logic [`PNS_NP_CODE_W-1:0] np_code;
  logic                      irq;
  int                        num_errors;
  int                        samples_checked;

  pns_regs i_dut (
    .MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .RX_ERR_EVT(rx_err), .FALSE_CARRIER_EVT(fc),
    .POLARITY_INV(pol), .SIGNAL_DETECT(sd), .DESCRAMBLER_LOCK(lock),
    .LCW_RECEIVED(lcw_rx), .LCW_EXCHANGED(lcw_ex), .LCW_TOGGLE(lcw_tog),
    .NP_NEXT_PAGE(np_next), .NP_MESSAGE_PAGE(np_msg), .NP_WILL_COMPLY_ACK(np_will_comply_ack),
    .NP_TOGGLE(np_tog), .NP_CODE(np_code), .IRQ(irq)
  );

  task automatic final_report();
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until the edge where pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic e_exp, output logic [31:0] r);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    chk("pslverr", {31'h0, e_exp}, {31'h0, pslverr});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e = 1'b0);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, e, r);
    chk("prdata", exp, r);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e = 1'b0);
    logic [31:0] r;
    apb(1'b1, a, d, e, r);
  endtask

  // Single-cycle event: 0 rx error, 1 false carrier, 2 page, 3 exchange
  task automatic pulse(input int k);
    @(posedge mclk);
    case (k)
      0: rx_err <= 1'b1;
      1: fc <= 1'b1;
      2: lcw_rx <= 1'b1;
      default: lcw_ex <= 1'b1;
    endcase
    @(posedge mclk);
    rx_err <= 1'b0;
    fc     <= 1'b0;
    lcw_rx <= 1'b0;
    lcw_ex <= 1'b0;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    final_report();
  end

  initial begin
    logic [7:0]  cnt_a [2];
    logic [31:0] cnt_b [2];
    cnt_a = '{A_RX, A_FC};
    cnt_b = '{32'h0000_2000, 32'h0000_0800};
    num_errors = 0;
    samples_checked = 0;
    {rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {rx_err, fc, pol, lcw_rx, lcw_ex, lcw_tog} = 6'h00;
    {sd, lock} = 2'h3;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    chk("np_code", 32'h1, {21'h0, np_code});
    chk("np_will_comply_ack", 32'h0, {31'h0, np_will_comply_ack});
    chk("np_tog", 32'h0, {31'h0, np_tog});
    chk("irq", 32'h0, {31'h0, irq});
    rdc(A_NP, 32'h0000_2001);
    rdc(A_IM, 32'h0);
    rdc(A_SS, 32'h0);
    rdc(A_SS, BASE);
    wr(A_NP, 32'hFFFF_FFFF);
    rdc(A_NP, 32'h0000_B7FF);
    chk("np_will_comply_ack", 32'h1, {31'h0, np_will_comply_ack});
    chk("np_msg", 32'h1, {31'h0, np_msg});
    chk("np_code", 32'h7FF, {21'h0, np_code});
    chk("np_next", 32'h1, {31'h0, np_next});
    wr(A_NP, 32'h0);
    chk("np_next", 32'h0, {31'h0, np_next});
    chk("np_msg", 32'h0, {31'h0, np_msg});
    chk("np_will_comply_ack", 32'h0, {31'h0, np_will_comply_ack});
    pulse(3);
    rdc(A_NP, 32'h0000_0800);
    chk("np_tog", 32'h1, {31'h0, np_tog});
    lcw_tog <= 1'b1;
    pulse(3);
    rdc(A_NP, 32'h0);
    wr(A_SS, 32'hFFFF_FFFF);
    rdc(A_SS, BASE);
    for (int k = 0; k < 2; k++) begin
      pulse(k);
      rdc(A_SS, BASE | cnt_b[k]);
      rdc(A_SS, BASE | cnt_b[k]);
      rdc(cnt_a[k], 32'h0);
      rdc(A_SS, BASE);
    end
    pol <= 1'b1;
    @(posedge mclk);
    pol <= 1'b0;
    rdc(A_SS, BASE | 32'h1000);
    rdc(A_SS, BASE | 32'h1000);
    rdc(A_TB, 32'h0000_0010);
    rdc(A_SS, BASE);
    pulse(2);
    rdc(A_SS, BASE | 32'h0100);
    rdc(A_SS, BASE | 32'h0100);
    rdc(A_EXP, 32'h0000_0002);
    rdc(A_EXP, 32'h0);
    rdc(A_SS, BASE);
    sd <= 1'b0;
    @(posedge mclk);
    sd <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(A_SS, 32'h0000_0200);
    rdc(A_SS, BASE);
    lock <= 1'b0;
    @(posedge mclk);
    lock <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(A_SS, 32'h0000_0400);
    rdc(A_SS, BASE);
    // Unmapped and misaligned: error, no data, no write
    rdc(8'h04, 32'h0, 1'b1);
    rdc(A_SS | 8'h01, 32'h0, 1'b1);
    wr(8'h20, 32'hFFFF, 1'b1);
    wr(A_NP | 8'h02, 32'hFFFF, 1'b1);
    rdc(A_NP, 32'h0);
    rdc(A_IS, 32'h0000_001F);
    rdc(A_IS, 32'h0);
    wr(A_IM, 32'h0000_0001);
    rdc(A_IM, 32'h0000_0001);
    pulse(1);
    repeat (4) @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    pulse(0);
    repeat (4) @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    rdc(A_IS, 32'h0000_0003);
    repeat (3) @(posedge mclk);
    chk("irq", 32'h0, {31'h0, irq});
    // Mid-run reset must restore defaults and re-arm the latch-low hold
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk("irq", 32'h0, {31'h0, irq});
    rdc(A_NP, 32'h0000_2001);
    rdc(A_SS, 32'h0);
    rdc(A_SS, BASE);
    final_report();
  end
endmodule

`default_nettype wire
